// File: src/iocfg_map.vh
`ifndef IOCFG_MAP_VH
`define IOCFG_MAP_VH

// Byte offsets within the 32-byte window.
`define IOCFG_OFS_SIM_CTRL 5'h11
`define IOCFG_OFS_CONV0_CTRL 5'h12
`define IOCFG_OFS_CONV0_HIGH 5'h13
`define IOCFG_OFS_CONV1_CTRL 5'h14
`define IOCFG_OFS_CONV1_HIGH 5'h15
`define IOCFG_OFS_EVENT_FLAGS 5'h1a
`define IOCFG_OFS_CONFIG 5'h1b
`define IOCFG_OFS_RSVD_FIRST 5'h1c
`define IOCFG_OFS_RSVD_LAST 5'h1f

// Configuration register.
`define IOCFG_CONFIG_RESET 8'h00
`define IOCFG_CFG_P1_LO 0
`define IOCFG_CFG_P1_HI 1
`define IOCFG_CFG_P2_LO 2
`define IOCFG_CFG_P2_HI 3
`define IOCFG_CFG_DIV_SEL 4
`define IOCFG_CFG_CONV_IEN 5
`define IOCFG_CFG_OUTSIDE_IEN 6
`define IOCFG_CFG_WRAP_IEN 7

// Event flag register.
`define IOCFG_FLG_CONV0 0
`define IOCFG_FLG_CONV1 1
`define IOCFG_FLG_OUTSIDE 2
`define IOCFG_FLG_WRAP 3

// Converter control byte.
`define IOCFG_CTL_PD_HIGH 7
`define IOCFG_CTL_PD_LOW 6
`define IOCFG_CTL_SAMPLING 5
`define IOCFG_CTL_SPAN 4
`define IOCFG_CTL_SIGNED 3
`define IOCFG_CTL_MUX_MSB 2
`define IOCFG_CTL_MUX_LSB 0

// Reserved offsets read back as this constant.
`define IOCFG_RSVD_READ 8'h00

// Timing, in converter clock cycles, and divider ratios.
`define IOCFG_ACQ_CYCLES 6
`define IOCFG_CONV_CYCLES 12
`define IOCFG_DIV_SLOW 8
`define IOCFG_DIV_FAST 4

`endif

// File: src/iocfg_conv_seq.v
`timescale 1ns/1ps
`default_nettype none
`include "iocfg_map.vh"

module iocfg_conv_seq #(
	parameter ACQ_CYCLES = `IOCFG_ACQ_CYCLES,
	parameter CONV_CYCLES = `IOCFG_CONV_CYCLES
) (
	input wire ref_clk,
	input wire nrst,
	input wire tick,
	input wire ctrl_wr,
	input wire [7:0] ctrl_byte,
	output reg [2:0] channel_reg,
	output reg span_reg,
	output reg bipolar_reg,
	output reg acquiring_reg,
	output reg converting_reg,
	output reg done_pulse_reg
);

	localparam [1:0] ST_IDLE = 2'b00;
	localparam [1:0] ST_ACQ_INT = 2'b01;
	localparam [1:0] ST_ACQ_HOST = 2'b10;
	localparam [1:0] ST_CONV = 2'b11;
	localparam [31:0] ACQ_LAST_FULL = ACQ_CYCLES - 1;
	localparam [31:0] CONV_LAST_FULL = CONV_CYCLES - 1;
	localparam [3:0] ACQ_LAST = ACQ_LAST_FULL[3:0];
	localparam [3:0] CONV_LAST = CONV_LAST_FULL[3:0];

	reg [1:0] state_reg;
	reg [1:0] state_next;
	reg [3:0] cnt_reg;
	reg [3:0] cnt_next;
	reg done_next;

	////////////////////////////////////////////////////////////////
	always @* begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		done_next = 1'b0;
		if (ctrl_wr) begin
			cnt_next = 4'h0;
			// A write during external sampling with the sampling bit clear ends the sample.
			if (ctrl_byte[`IOCFG_CTL_SAMPLING]) begin
				state_next = ST_ACQ_HOST;
			end else if (state_reg == ST_ACQ_HOST) begin
				state_next = ST_CONV;
			end else begin
				state_next = ST_ACQ_INT;
			end
		end else if (tick) begin
			case (state_reg)
				ST_ACQ_INT: begin
					if (cnt_reg == ACQ_LAST) begin
						state_next = ST_CONV;
						cnt_next = 4'h0;
					end else begin
						cnt_next = cnt_reg + 4'h1;
					end
				end
				ST_CONV: begin
					if (cnt_reg == CONV_LAST) begin
						state_next = ST_IDLE;
						cnt_next = 4'h0;
						done_next = 1'b1;
					end else begin
						cnt_next = cnt_reg + 4'h1;
					end
				end
				default: begin
					cnt_next = cnt_reg;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////
	always @(posedge ref_clk) begin
		if (!nrst) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 4'h0;
			channel_reg <= 3'h0;
			span_reg <= 1'b0;
			bipolar_reg <= 1'b0;
			acquiring_reg <= 1'b0;
			converting_reg <= 1'b0;
			done_pulse_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			done_pulse_reg <= done_next;
			acquiring_reg <= (state_next == ST_ACQ_INT) || (state_next == ST_ACQ_HOST);
			converting_reg <= (state_next == ST_CONV);
			if (ctrl_wr) begin
				channel_reg <= ctrl_byte[`IOCFG_CTL_MUX_MSB:`IOCFG_CTL_MUX_LSB];
				span_reg <= ctrl_byte[`IOCFG_CTL_SPAN];
				bipolar_reg <= ctrl_byte[`IOCFG_CTL_SIGNED];
			end
		end
	end

endmodule
`default_nettype wire

// File: src/iocfg_top.v
`timescale 1ns/1ps
`default_nettype none
`include "iocfg_map.vh"

module iocfg_top #(
	parameter NUM_CONV = 2
) (
	input wire ref_clk,
	input wire nrst,
	input wire [4:0] bus_addr,
	input wire [7:0] bus_wdata,
	input wire bus_wr,
	input wire bus_rd,
	output reg [7:0] bus_rdata_reg,
	input wire [11:0] conv0_result,
	input wire [11:0] conv1_result,
	input wire outside_event_in,
	input wire count_wrap_in,
	output reg [7:0] port_one_drive_n_reg,
	output reg [7:0] port_two_drive_n_reg,
	output reg converter_clk_reg,
	output reg host_irq_reg,
	output wire [2:0] conv0_channel,
	output wire conv0_span,
	output wire conv0_bipolar,
	output wire conv0_acquiring,
	output wire conv0_converting,
	output wire [2:0] conv1_channel,
	output wire conv1_span,
	output wire conv1_bipolar,
	output wire conv1_acquiring,
	output wire conv1_converting
);

	reg [7:0] module_configuration_reg;
	reg [7:0] event_flag_reg;
	reg [7:0] event_flag_next;
	reg [2:0] div_cnt_reg;
	reg div_sel_active_reg;
	reg conv_tick_reg;
	reg [7:0] rdata_next;
	wire [NUM_CONV-1:0] done_pulse;
	wire [NUM_CONV-1:0] ctrl_wr;
	wire [NUM_CONV-1:0] data_rd;
	wire [2:0] channel [0:NUM_CONV-1];
	wire [NUM_CONV-1:0] span;
	wire [NUM_CONV-1:0] bipolar;
	wire [NUM_CONV-1:0] acquiring;
	wire [NUM_CONV-1:0] converting;
	wire clk_next;

	// Offset of converter idx's control/low-data byte.
	function [4:0] conv_low_ofs;
		input integer idx;
		begin
			conv_low_ofs = (idx == 0) ? `IOCFG_OFS_CONV0_CTRL : `IOCFG_OFS_CONV1_CTRL;
		end
	endfunction

	// Upper result byte: sign-extended in signed coding, zero-filled otherwise.
	function [7:0] high_byte;
		input [11:0] result;
		input signed_mode;
		begin
			high_byte = {{4{signed_mode & result[11]}}, result[11:8]};
		end
	endfunction

	////////////////////////////////////////////////////////////////
	// Converter clock divider.
	// The selection is only taken over at the wrap to zero, where both divided
	// phases are low, so a change of ratio cannot leave a runt pulse.
	assign clk_next = div_sel_active_reg ? div_cnt_reg[1] : div_cnt_reg[2];

	always @(posedge ref_clk) begin
		if (!nrst) begin
			div_cnt_reg <= 3'h0;
			div_sel_active_reg <= 1'b0;
			converter_clk_reg <= 1'b0;
			conv_tick_reg <= 1'b0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
			if (div_cnt_reg == 3'h7) begin
				div_sel_active_reg <= module_configuration_reg[`IOCFG_CFG_DIV_SEL];
			end
			converter_clk_reg <= clk_next;
			conv_tick_reg <= clk_next & ~converter_clk_reg;
		end
	end

	////////////////////////////////////////////////////////////////
	// Converter sequencers, both paced by the one shared tick.
	genvar gi;
	generate
		for (gi = 0; gi < NUM_CONV; gi = gi + 1) begin : g_conv
			assign ctrl_wr[gi] = bus_wr && ((bus_addr == conv_low_ofs(gi)) ||
				(bus_addr == `IOCFG_OFS_SIM_CTRL));
			assign data_rd[gi] = bus_rd && (bus_addr == conv_low_ofs(gi));
			iocfg_conv_seq u_seq (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.tick(conv_tick_reg),
				.ctrl_wr(ctrl_wr[gi]),
				.ctrl_byte(bus_wdata),
				.channel_reg(channel[gi]),
				.span_reg(span[gi]),
				.bipolar_reg(bipolar[gi]),
				.acquiring_reg(acquiring[gi]),
				.converting_reg(converting[gi]),
				.done_pulse_reg(done_pulse[gi])
			);
		end
	endgenerate

	assign conv0_channel = channel[0];
	assign conv0_span = span[0];
	assign conv0_bipolar = bipolar[0];
	assign conv0_acquiring = acquiring[0];
	assign conv0_converting = converting[0];
	assign conv1_channel = channel[1];
	assign conv1_span = span[1];
	assign conv1_bipolar = bipolar[1];
	assign conv1_acquiring = acquiring[1];
	assign conv1_converting = converting[1];

	////////////////////////////////////////////////////////////////
	// Event flags. In every case a set in the same cycle beats a clear.
	always @* begin
		event_flag_next = event_flag_reg;
		if (ctrl_wr[0] || data_rd[0]) begin
			event_flag_next[`IOCFG_FLG_CONV0] = 1'b0;
		end
		if (ctrl_wr[1] || data_rd[1]) begin
			event_flag_next[`IOCFG_FLG_CONV1] = 1'b0;
		end
		if (bus_wr && (bus_addr == `IOCFG_OFS_EVENT_FLAGS)) begin
			if (bus_wdata[`IOCFG_FLG_OUTSIDE]) begin
				event_flag_next[`IOCFG_FLG_OUTSIDE] = 1'b0;
			end
			if (bus_wdata[`IOCFG_FLG_WRAP]) begin
				event_flag_next[`IOCFG_FLG_WRAP] = 1'b0;
			end
		end
		if (done_pulse[0]) begin
			event_flag_next[`IOCFG_FLG_CONV0] = 1'b1;
		end
		if (done_pulse[1]) begin
			event_flag_next[`IOCFG_FLG_CONV1] = 1'b1;
		end
		if (outside_event_in) begin
			event_flag_next[`IOCFG_FLG_OUTSIDE] = 1'b1;
		end
		if (count_wrap_in) begin
			event_flag_next[`IOCFG_FLG_WRAP] = 1'b1;
		end
		event_flag_next[7:4] = 4'h0;
	end

	////////////////////////////////////////////////////////////////
	// Read data. Write-only and unmapped offsets read as zero; reserved as a constant.
	always @* begin
		rdata_next = 8'h00;
		if (bus_addr == `IOCFG_OFS_CONFIG) begin
			rdata_next = module_configuration_reg;
		end else if (bus_addr == `IOCFG_OFS_EVENT_FLAGS) begin
			rdata_next = event_flag_reg;
		end else if (bus_addr == `IOCFG_OFS_CONV0_CTRL) begin
			rdata_next = conv0_result[7:0];
		end else if (bus_addr == `IOCFG_OFS_CONV0_HIGH) begin
			rdata_next = high_byte(conv0_result, bipolar[0]);
		end else if (bus_addr == `IOCFG_OFS_CONV1_CTRL) begin
			rdata_next = conv1_result[7:0];
		end else if (bus_addr == `IOCFG_OFS_CONV1_HIGH) begin
			rdata_next = high_byte(conv1_result, bipolar[1]);
		end else if (bus_addr >= `IOCFG_OFS_RSVD_FIRST) begin
			rdata_next = `IOCFG_RSVD_READ;
		end
	end

	////////////////////////////////////////////////////////////////
	// Registers and pin controls.
	always @(posedge ref_clk) begin
		if (!nrst) begin
			module_configuration_reg <= `IOCFG_CONFIG_RESET;
			event_flag_reg <= 8'h00;
			bus_rdata_reg <= 8'h00;
			port_one_drive_n_reg <= 8'hff;
			port_two_drive_n_reg <= 8'hff;
			host_irq_reg <= 1'b0;
		end else begin
			if (bus_wr && (bus_addr == `IOCFG_OFS_CONFIG)) begin
				module_configuration_reg <= bus_wdata;
			end
			event_flag_reg <= event_flag_next;
			if (bus_rd) begin
				bus_rdata_reg <= rdata_next;
			end
			// Drive enables are active low: a one in a direction bit turns its nibble to output, or only bits 1:0 for the port two low bit.
			port_one_drive_n_reg[3:0] <= {4{~module_configuration_reg[`IOCFG_CFG_P1_LO]}};
			port_one_drive_n_reg[7:4] <= {4{~module_configuration_reg[`IOCFG_CFG_P1_HI]}};
			port_two_drive_n_reg[1:0] <= {2{~module_configuration_reg[`IOCFG_CFG_P2_LO]}};
			port_two_drive_n_reg[3:2] <= 2'b11;
			port_two_drive_n_reg[7:4] <= {4{~module_configuration_reg[`IOCFG_CFG_P2_HI]}};
			host_irq_reg <= (module_configuration_reg[`IOCFG_CFG_CONV_IEN] &
				(event_flag_reg[`IOCFG_FLG_CONV0] | event_flag_reg[`IOCFG_FLG_CONV1])) |
				(module_configuration_reg[`IOCFG_CFG_OUTSIDE_IEN] & event_flag_reg[`IOCFG_FLG_OUTSIDE]) |
				(module_configuration_reg[`IOCFG_CFG_WRAP_IEN] & event_flag_reg[`IOCFG_FLG_WRAP]);
		end
	end

endmodule
`default_nettype wire

// File: test/iocfg_conv_model.sv
`timescale 1ns/1ps
`default_nettype none
// Each result carries its converter index and the latched fields, so a swapped channel shows in read data.
module iocfg_conv_model (
	input wire logic [2:0] ch0,
	input wire logic span0,
	input wire logic bip0,
	input wire logic [2:0] ch1,
	input wire logic span1,
	input wire logic bip1,
	output logic [11:0] res0,
	output logic [11:0] res1
);
	assign res0 = {1'h0, bip0, span0, ch0, 6'h2a};
	assign res1 = {1'h1, bip1, span1, ch1, 6'h2a};
endmodule
`default_nettype wire

// File: test/iocfg_properties.sv
`timescale 1ns/1ps
`default_nettype none
module iocfg_properties (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [4:0] bus_addr,
	input wire logic [7:0] bus_wdata,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_rdata_reg,
	input wire logic [7:0] port_one_drive_n_reg,
	input wire logic [7:0] port_two_drive_n_reg,
	input wire logic converter_clk_reg,
	input wire logic host_irq_reg,
	input wire logic [2:0] conv0_channel,
	input wire logic conv0_span,
	input wire logic conv0_bipolar,
	input wire logic conv0_acquiring,
	input wire logic conv0_converting
);
	logic [7:0] cfg_reg, cfg_d_reg, wd_reg;
	logic cfg_wr_d_reg, c0_wr_d_reg, clk_d_reg;
	logic [3:0] gap_reg, acq_reg, cnv_reg;
	logic [4:0] age_reg;
	wire logic cfg_wr = bus_wr && bus_addr == 5'h1b;
	wire logic c0_wr = bus_wr && (bus_addr == 5'h12 || bus_addr == 5'h11);
	wire logic rise = converter_clk_reg && !clk_d_reg;
	// Ticks are counted as the sequencer sees them, in the same cycle as the divided clock output rises.
	always @(posedge ref_clk) begin
		cfg_reg <= !nrst ? 8'h00 : cfg_wr ? bus_wdata : cfg_reg;
		cfg_d_reg <= cfg_reg;
		wd_reg <= bus_wdata;
		cfg_wr_d_reg <= cfg_wr;
		c0_wr_d_reg <= c0_wr;
		clk_d_reg <= converter_clk_reg;
		gap_reg <= rise ? 4'h1 : gap_reg + 4'h1;
		age_reg <= (!nrst || cfg_wr) ? 5'h00 : age_reg + {4'h0, age_reg != 5'h1f};
		acq_reg <= (c0_wr || !conv0_acquiring) ? 4'h0 : acq_reg + {3'h0, rise};
		cnv_reg <= (c0_wr || !conv0_converting) ? 4'h0 : cnv_reg + {3'h0, rise};
	end
	////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	sequence s_cfg_write;
		bus_wr && bus_addr == 5'h1b;
	endsequence
	sequence s_c0_write;
		c0_wr;
	endsequence
	a_cfg_read_back: assert property (s_cfg_write ##2 (bus_rd && bus_addr == 5'h1b)
		|=> bus_rdata_reg == $past(bus_wdata, 3)) else $error("config read back wrong");
	a_port_one_dir: assert property (!cfg_wr_d_reg
		|-> port_one_drive_n_reg == ~{{4{cfg_reg[1]}}, {4{cfg_reg[0]}}}) else $error("port one direction wrong");
	a_port_two_dir: assert property (!cfg_wr_d_reg
		|-> port_two_drive_n_reg == ~{{4{cfg_reg[3]}}, 2'h0, {2{cfg_reg[2]}}}) else $error("port two direction wrong");
	a_divider_period: assert property ($rose(converter_clk_reg) && age_reg == 5'h1f
		|-> gap_reg == (cfg_reg[4] ? 4'h4 : 4'h8)) else $error("converter clock period wrong");
	a_irq_needs_enable: assert property (host_irq_reg
		|-> (cfg_reg[7:5] | cfg_d_reg[7:5]) != 3'h0) else $error("interrupt without enable");
	a_ctl_fields_latch: assert property (s_c0_write |=> conv0_channel == wd_reg[2:0]
		&& conv0_span == wd_reg[4] && conv0_bipolar == wd_reg[3] && (conv0_acquiring || conv0_converting))
		else $error("control write not taken");
	a_ctl_clears_flag: assert property (bus_wr && bus_addr == 5'h12 ##2 (bus_rd && bus_addr == 5'h1a)
		|=> !bus_rdata_reg[0]) else $error("done flag not cleared");
	a_acq_six_ticks: assert property ($past(nrst) && $fell(conv0_acquiring) && !c0_wr_d_reg
		|-> acq_reg == 4'h6) else $error("acquire length wrong");
	a_conv_twelve_ticks: assert property ($past(nrst) && $fell(conv0_converting) && !c0_wr_d_reg
		|-> cnv_reg == 4'hc) else $error("convert length wrong");
endmodule
bind iocfg_top iocfg_properties u_props (.ref_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd,
	.bus_rdata_reg, .port_one_drive_n_reg, .port_two_drive_n_reg, .converter_clk_reg, .host_irq_reg,
	.conv0_channel, .conv0_span, .conv0_bipolar, .conv0_acquiring, .conv0_converting);
`default_nettype wire

// File: test/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic ref_clk = 1'h0, nrst = 1'h0, bus_wr = 1'h0, bus_rd = 1'h0, outside_event_in = 1'h0, count_wrap_in = 1'h0;
	logic [4:0] bus_addr = 5'h00;
	logic [7:0] bus_wdata = 8'h00, d;
	wire logic [7:0] bus_rdata_reg, port_one_drive_n_reg, port_two_drive_n_reg;
	wire logic [11:0] conv0_result, conv1_result;
	wire logic [2:0] conv0_channel, conv1_channel;
	wire logic converter_clk_reg, host_irq_reg, conv0_span, conv0_bipolar, conv0_acquiring, conv0_converting;
	wire logic conv1_span, conv1_bipolar, conv1_acquiring, conv1_converting;
	int failures = 0, comparisons = 0, cycles = 0;
	always #5 ref_clk = ~ref_clk;
	iocfg_top DUT (.ref_clk, .nrst, .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata_reg, .conv0_result,
		.conv1_result, .outside_event_in, .count_wrap_in, .port_one_drive_n_reg, .port_two_drive_n_reg,
		.converter_clk_reg, .host_irq_reg, .conv0_channel, .conv0_span, .conv0_bipolar, .conv0_acquiring,
		.conv0_converting, .conv1_channel, .conv1_span, .conv1_bipolar, .conv1_acquiring, .conv1_converting);
	iocfg_conv_model u_conv (.ch0(conv0_channel), .span0(conv0_span), .bip0(conv0_bipolar),
		.ch1(conv1_channel), .span1(conv1_span), .bip1(conv1_bipolar), .res0(conv0_result), .res1(conv1_result));
	////////////////////////////////
	task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("ERROR %s expected %h seen %h", n, exp, got);
		end
	endtask
	task print_verdict;
		if (failures == 0 && comparisons > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Bus tasks start and end just after a rising edge; control bytes always keep bits 7:6 at zero.
	// One idle edge closes each access, so a strobe is never dropped and raised again in one time step.
	task wr(input logic [4:0] a, input logic [7:0] v);
		bus_addr = a;
		bus_wdata = v;
		bus_wr = 1'h1;
		@(posedge ref_clk) #1;
		bus_wr = 1'h0;
		@(posedge ref_clk) #1;
	endtask
	task rd(input logic [4:0] a);
		bus_addr = a;
		bus_rd = 1'h1;
		@(posedge ref_clk) #1;
		bus_rd = 1'h0;
		@(posedge ref_clk) #1;
	endtask
	task wait_flag(input logic [7:0] m);
		rd(5'h1a);
		for (int k = 0; k < 400 && (bus_rdata_reg & m) != m; k++) rd(5'h1a);
	endtask
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			print_verdict;
		end
	end
	////////////////////////////////
	initial begin
		repeat (20) @(posedge ref_clk);
		#1 nrst = 1'h1;
		rd(5'h1b);
		chk("config reset", bus_rdata_reg, 8'h00);
		for (int i = 0; i < 4; i++) begin
			d = 8'h01 << i;
			wr(5'h1b, d);
			rd(5'h1b);
			chk("config", bus_rdata_reg, d);
			@(posedge ref_clk) #1;
			chk("port one", port_one_drive_n_reg, ~{{4{d[1]}}, {4{d[0]}}});
			chk("port two", port_two_drive_n_reg, ~{{4{d[3]}}, 2'h0, {2{d[2]}}});
		end
		wr(5'h1d, 8'hff);
		rd(5'h1d);
		chk("reserved", bus_rdata_reg, 8'h00);
		rd(5'h1b);
		chk("config kept", bus_rdata_reg, 8'h08);
		for (int i = 0; i < 2; i++) begin
			wr(5'h1b, 8'h00);
			outside_event_in = (i == 0);
			count_wrap_in = (i == 1);
			@(posedge ref_clk) #1;
			outside_event_in = 1'h0;
			count_wrap_in = 1'h0;
			repeat (3) @(posedge ref_clk);
			#1 chk("irq masked", host_irq_reg, 8'h00);
			wr(5'h1b, 8'h40 << i);
			repeat (2) @(posedge ref_clk);
			#1 chk("irq raised", host_irq_reg, 8'h01);
			wr(5'h1a, 8'h04 << i);
			repeat (2) @(posedge ref_clk);
			#1 chk("irq cleared", host_irq_reg, 8'h00);
		end
		// The bench clock is far above a real host bus, so only the ratio is exercised here.
		wr(5'h1b, 8'h20);
		wr(5'h12, 8'h1d);
		rd(5'h1a);
		chk("flag cleared", bus_rdata_reg, 8'h00);
		wait_flag(8'h01);
		chk("done flag", bus_rdata_reg, 8'h01);
		chk("done irq", host_irq_reg, 8'h01);
		rd(5'h12);
		chk("low byte", bus_rdata_reg, 8'h6a);
		rd(5'h13);
		chk("high byte", bus_rdata_reg, 8'h07);
		rd(5'h1a);
		chk("flag read clear", bus_rdata_reg, 8'h00);
		chk("irq dropped", host_irq_reg, 8'h00);
		wr(5'h1b, 8'h30);
		wr(5'h11, 8'h1d);
		wait_flag(8'h03);
		rd(5'h14);
		chk("pair low byte", bus_rdata_reg, 8'h6a);
		rd(5'h15);
		chk("pair high byte", bus_rdata_reg, 8'hff);
		rd(5'h1a);
		chk("one flag left", bus_rdata_reg, 8'h01);
		wr(5'h12, 8'h1d);
		rd(5'h1a);
		chk("flag cleared by write", bus_rdata_reg, 8'h00);
		wr(5'h14, 8'h22);
		repeat (300) @(posedge ref_clk);
		#1 chk("still sampling", conv1_acquiring, 8'h01);
		rd(5'h1a);
		chk("no early done", bus_rdata_reg, 8'h01);
		wr(5'h14, 8'h02);
		chk("converting", conv1_converting, 8'h01);
		wait_flag(8'h02);
		rd(5'h14);
		chk("held low byte", bus_rdata_reg, 8'haa);
		rd(5'h15);
		chk("held high byte", bus_rdata_reg, 8'h08);
		print_verdict;
	end
endmodule
`default_nettype wire
